// ### mcmc_pkg.sv
// metering compute-mode configuration: shared constants and types
// assumes register indices map to byte addresses at index * 4
package mcmc_pkg;

   // ==========================================================
   // register indices (byte address = index * 4)
   localparam int               IDX_W            = 16;
   localparam int               ADDR_LSB         = 2;
   localparam logic [IDX_W-1:0] COMPUTE_MODE_IDX = 16'hE60E;
   localparam logic [IDX_W-1:0] PULSE_CFG_IDX    = 16'hE610;
   localparam logic [IDX_W-1:0] NOM_VOLT_IDX     = 16'hE620;
   localparam logic [IDX_W-1:0] STATUS_IDX       = 16'hE621;

   // ==========================================================
   // reset values and writable masks
   localparam logic [15:0] COMPUTE_MODE_RST  = 16'h01FF;
   localparam logic [15:0] PULSE_CFG_RST     = 16'h0E88;
   localparam logic [15:0] COMPUTE_MODE_MASK = 16'h7FFF;
   localparam logic [15:0] PULSE_CFG_MASK    = 16'h7FFF;

   // ==========================================================
   // field positions
   localparam int SEL_W      = 3;   // phase mask and quantity select width
   localparam int PHASES     = 3;
   localparam int OUTPUTS    = 3;
   localparam int ANGLE_LSB  = 9;
   localparam int ANGLE_W    = 2;
   localparam int NOMINAL_VOLTAGE_VALUE_LSB   = 11;
   localparam int FREQ_BIT   = 14;
   localparam int RSVD_BIT   = 15;

   // ==========================================================
   // quantity codes of a pulse output; 5..7 are illegal
   typedef enum logic [2:0] {
      Q_TOT_ACT    = 3'h0,
      Q_TOT_REACT  = 3'h1,
      Q_APPARENT   = 3'h2,
      Q_FUND_ACT   = 3'h3,
      Q_FUND_REACT = 3'h4
   } mcmc_qty_t;

   // angle measurement modes
   typedef enum logic [1:0] {
      ANG_VI  = 2'h0,
      ANG_VV  = 2'h1,
      ANG_II  = 2'h2,
      ANG_OFF = 2'h3
   } mcmc_angle_t;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mcmc_pkg

// ### mcmc_axil_slave.sv
// axi4-lite slave front end: turns bus transfers into register strobes
// assumes the register side answers decode and read data combinationally
`timescale 1ns/1ps
`default_nettype none
module mcmc_axil_slave #(
   parameter int AW = 18
) (
   input  wire logic                       clk,
   input  wire logic                       arst_n,
   input  wire logic [AW-1:0]              s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [AW-1:0]              s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic                            wr_en,
   output logic [mcmc_pkg::IDX_W-1:0]      wr_idx,
   output logic [31:0]                     wr_data,
   output logic [3:0]                      wr_strb,
   input  wire logic                       wr_ok,
   output logic [mcmc_pkg::IDX_W-1:0]      rd_idx,
   input  wire logic [31:0]                rd_data,
   input  wire logic                       rd_ok
);
   if (AW != mcmc_pkg::IDX_W + mcmc_pkg::ADDR_LSB) begin : g_chk
      $error("address width must cover the register index");
   end

   // ==========================================================
   // channel state
   logic                       aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [mcmc_pkg::IDX_W-1:0] aw_idx_q, aw_idx_d;
   logic [31:0]                wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0]                 wstrb_q, wstrb_d;
   logic                       bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]                 bresp_q, bresp_d, rresp_q, rresp_d;

   // address and data are held apart so either may come first
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready  = !w_full_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign wr_en         = aw_full_q && w_full_q;
   assign wr_idx        = aw_idx_q;
   assign wr_data       = wdata_q;
   assign wr_strb       = wstrb_q;
   assign rd_idx        = s_axi_araddr[AW-1:mcmc_pkg::ADDR_LSB];
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // next state of both directions
   always_comb begin
      aw_full_d = aw_full_q;
      aw_idx_d  = aw_idx_q;
      w_full_d  = w_full_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_d = 1'b1;
         aw_idx_d  = s_axi_awaddr[AW-1:mcmc_pkg::ADDR_LSB];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end
      if (wr_en) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = wr_ok ? mcmc_pkg::RESP_OKAY : mcmc_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rdata_d  = rd_ok ? rd_data : 32'h0000_0000;
         rresp_d  = rd_ok ? mcmc_pkg::RESP_OKAY : mcmc_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_full_q <= 1'b0;
         aw_idx_q  <= '0;
         w_full_q  <= 1'b0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= 2'h0;
      end else begin
         aw_full_q <= aw_full_d;
         aw_idx_q  <= aw_idx_d;
         w_full_q  <= w_full_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // a response stays up until the master takes it
   bvalid_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
      else $error("write response dropped before bready");

endmodule : mcmc_axil_slave
`default_nettype wire

// ### mcmc_pulse_sum.sv
// one pulse output's quantity mux and phase-masked sum
// assumes per-phase quantities are signed and already registered upstream
`timescale 1ns/1ps
`default_nettype none
module mcmc_pulse_sum #(
   parameter int PW = 24
) (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic [2:0]            phase_en,
   input  wire logic [2:0]            qty_sel,
   input  wire logic [2:0][PW-1:0]    tot_act,
   input  wire logic [2:0][PW-1:0]    tot_react,
   input  wire logic [2:0][PW-1:0]    apparent,
   input  wire logic [2:0][PW-1:0]    fund_act,
   input  wire logic [2:0][PW-1:0]    fund_react,
   output logic signed [PW+1:0]       sum_q,
   output logic                       active_q
);
   logic [2:0][PW-1:0] pick;
   logic signed [PW+1:0] sum_d;
   logic                 active_d;

   // ==========================================================
   // quantity select, then sum of enabled phases
   // reserved codes stop the output rather than guess a quantity
   always_comb begin
      pick     = '0;
      active_d = 1'b1;
      unique case (mcmc_pkg::mcmc_qty_t'(qty_sel))
         mcmc_pkg::Q_TOT_ACT:    pick = tot_act;
         mcmc_pkg::Q_TOT_REACT:  pick = tot_react;
         mcmc_pkg::Q_APPARENT:   pick = apparent;
         mcmc_pkg::Q_FUND_ACT:   pick = fund_act;
         mcmc_pkg::Q_FUND_REACT: pick = fund_react;
         default:                active_d = 1'b0;
      endcase
      sum_d = '0;
      for (int p = 0; p < mcmc_pkg::PHASES; p++) begin
         if (phase_en[p] && active_d) begin
            sum_d = sum_d + (PW+2)'(signed'(pick[p]));
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sum_q    <= '0;
         active_q <= 1'b0;
      end else begin
         sum_q    <= sum_d;
         active_q <= active_d;
      end
   end

   // checks start one edge after reset release; the edge that releases
   // reset still shows reset values in the registers
   logic live_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         live_q <= 1'b0;
      end else begin
         live_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n || !live_q);

   reserved_quiet_a: assert property (
      qty_sel > 3'h4 |=> !active_q && sum_q == '0)
      else $error("reserved quantity code still produces output");

   all_phase_sum_a: assert property (
      qty_sel == 3'h0 && phase_en == 3'h7 |=> sum_q ==
         $past((PW+2)'(signed'(tot_act[0])) + (PW+2)'(signed'(tot_act[1]))
            + (PW+2)'(signed'(tot_act[2]))))
      else $error("three-phase active total wrong");

endmodule : mcmc_pulse_sum
`default_nettype wire

// ### mcmc_top.sv
// metering compute-mode configuration bank with its steered datapath
// assumes per-phase powers and rms values arrive synchronous to clk
//
// Summary of operation
// - bits 0..2 add phases A, B, C into pulse output 1 sum.
// - bits 3..5 add phases A, B, C into pulse output 2 sum.
// - bits 6..8 add phases A, B, C into pulse output 3 sum.
// - bits 10:9 choose V-I, V-V, I-I angles, or no angle measurement.
// - nominal-voltage enable bits make apparent power use the nominal voltage.
// - with the enable clear, apparent power uses measured rms voltage.
// - bit 15 resets to 0 and does nothing.
// - pulse output 1 code 000 selects summed total active power.
// - codes 1..4 pick other quantities; codes 5..7 stop the output.
`timescale 1ns/1ps
`default_nettype none
module mcmc_top #(
   parameter int AW = 18,
   parameter int PW = 24,
   parameter int VW = 24
) (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   // axi4-lite register port
   input  wire logic [AW-1:0]         s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AW-1:0]         s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // per-phase measurements, index 0 = phase A
   input  wire logic [2:0][PW-1:0]    tot_act_power,
   input  wire logic [2:0][PW-1:0]    tot_react_power,
   input  wire logic [2:0][PW-1:0]    fund_act_power,
   input  wire logic [2:0][PW-1:0]    fund_react_power,
   input  wire logic [2:0][VW-1:0]    volt_rms,
   input  wire logic [2:0][VW-1:0]    curr_rms,
   // results
   output logic [2:0][PW-1:0]         apparent_power_q,
   output logic [2:0][PW+1:0]         pulse_out_sum_q,
   output logic [2:0]                 pulse_out_active_q,
   output logic                       angle_volt_curr_q,
   output logic                       angle_volt_volt_q,
   output logic                       angle_curr_curr_q,
   output logic                       line_frequency_select
);
   // ==========================================================
   // parameter checks
   if (PW < 2 || PW - 1 > 2 * VW || VW > 32) begin : g_chk
      $error("power or rms width out of range for the product or the bus word");
   end

   // ==========================================================
   // bus front end
   logic                       wr_en, wr_ok, rd_ok;
   logic [mcmc_pkg::IDX_W-1:0] wr_idx, rd_idx;
   logic [31:0]                wr_data, rd_data;
   logic [3:0]                 wr_strb;

   mcmc_axil_slave #(.AW(AW)) u_bus (
      .clk           (clk),
      .arst_n        (arst_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_idx        (wr_idx),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_ok         (wr_ok),
      .rd_idx        (rd_idx),
      .rd_data       (rd_data),
      .rd_ok         (rd_ok)
   );

   // ==========================================================
   // register file
   logic [15:0]   cm_q, cm_d, pc_q, pc_d;
   logic [VW-1:0] nominal_voltage_value_q, nominal_voltage_value_d;

   // byte-lane merge; bits above the register width are dropped
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // merged write words; a function result cannot be part-selected directly
   logic [31:0] cm_merge, pc_merge, nominal_voltage_value_merge;

   assign cm_merge   = merge({16'h0000, cm_q}, wr_data, wr_strb);
   assign pc_merge   = merge({16'h0000, pc_q}, wr_data, wr_strb);
   assign nominal_voltage_value_merge = merge(32'(nominal_voltage_value_q), wr_data, wr_strb);

   // writes to the status word are accepted but change nothing
   assign wr_ok = wr_idx == mcmc_pkg::COMPUTE_MODE_IDX ||
                  wr_idx == mcmc_pkg::PULSE_CFG_IDX ||
                  wr_idx == mcmc_pkg::NOM_VOLT_IDX ||
                  wr_idx == mcmc_pkg::STATUS_IDX;

   // register next values
   always_comb begin
      cm_d   = cm_q;
      pc_d   = pc_q;
      nominal_voltage_value_d = nominal_voltage_value_q;
      if (wr_en) begin
         unique case (wr_idx)
            mcmc_pkg::COMPUTE_MODE_IDX:
               cm_d = cm_merge[15:0] & mcmc_pkg::COMPUTE_MODE_MASK;
            mcmc_pkg::PULSE_CFG_IDX:
               pc_d = pc_merge[15:0] & mcmc_pkg::PULSE_CFG_MASK;
            mcmc_pkg::NOM_VOLT_IDX:
               nominal_voltage_value_d = nominal_voltage_value_merge[VW-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cm_q   <= mcmc_pkg::COMPUTE_MODE_RST;
         pc_q   <= mcmc_pkg::PULSE_CFG_RST;
         nominal_voltage_value_q <= '0;
      end else begin
         cm_q   <= cm_d;
         pc_q   <= pc_d;
         nominal_voltage_value_q <= nominal_voltage_value_d;
      end
   end

   // read mux; the reserved top bit is never stored so reads it as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      unique case (rd_idx)
         mcmc_pkg::COMPUTE_MODE_IDX: rd_data = {16'h0000, cm_q};
         mcmc_pkg::PULSE_CFG_IDX:    rd_data = {16'h0000, pc_q};
         mcmc_pkg::NOM_VOLT_IDX:     rd_data = 32'(nominal_voltage_value_q);
         mcmc_pkg::STATUS_IDX:       rd_data = {26'h0, angle_volt_curr_q,
                                        angle_volt_volt_q, angle_curr_curr_q,
                                        pulse_out_active_q};
         default:                    rd_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // angle mode decode and line frequency
   logic [2:0] angle_d;

   always_comb begin
      unique case (mcmc_pkg::mcmc_angle_t'(cm_q[mcmc_pkg::ANGLE_LSB +: mcmc_pkg::ANGLE_W]))
         mcmc_pkg::ANG_VI:  angle_d = 3'h4;
         mcmc_pkg::ANG_VV:  angle_d = 3'h2;
         mcmc_pkg::ANG_II:  angle_d = 3'h1;
         mcmc_pkg::ANG_OFF: angle_d = 3'h0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {angle_volt_curr_q, angle_volt_volt_q, angle_curr_curr_q} <= 3'h4;
      end else begin
         {angle_volt_curr_q, angle_volt_volt_q, angle_curr_curr_q} <= angle_d;
      end
   end

   // frequency choice is software's to make; the block only passes it on
   assign line_frequency_select = cm_q[mcmc_pkg::FREQ_BIT];

   // ==========================================================
   // apparent power per phase
   // the multiplier sees the nominal voltage, not rms, when enabled;
   // one register stage keeps the product off the sum's timing path
   logic [2:0][PW-1:0] apparent_d;

   for (genvar p = 0; p < mcmc_pkg::PHASES; p++) begin : g_phase
      logic [VW-1:0]   volt_pick;
      logic [2*VW-1:0] prod;
      assign volt_pick = cm_q[mcmc_pkg::NOMINAL_VOLTAGE_VALUE_LSB + p] ? nominal_voltage_value_q
                                                      : volt_rms[p];
      assign prod = volt_pick * curr_rms[p];
      assign apparent_d[p] = {1'b0, prod[2*VW-1 -: PW-1]};
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         apparent_power_q <= '0;
      end else begin
         apparent_power_q <= apparent_d;
      end
   end

   // ==========================================================
   // three pulse-output sums
   // each output takes its own phase mask and quantity field
   for (genvar c = 0; c < mcmc_pkg::OUTPUTS; c++) begin : g_out
      logic signed [PW+1:0] sum;
      mcmc_pulse_sum #(.PW(PW)) u_sum (
         .clk        (clk),
         .arst_n     (arst_n),
         .phase_en   (cm_q[c*mcmc_pkg::SEL_W +: mcmc_pkg::SEL_W]),
         .qty_sel    (pc_q[c*mcmc_pkg::SEL_W +: mcmc_pkg::SEL_W]),
         .tot_act    (tot_act_power),
         .tot_react  (tot_react_power),
         .apparent   (apparent_power_q),
         .fund_act   (fund_act_power),
         .fund_react (fund_react_power),
         .sum_q      (sum),
         .active_q   (pulse_out_active_q[c])
      );
      assign pulse_out_sum_q[c] = sum;
   end

   // ==========================================================
   // checks
   // full-width products for the apparent-power checks
   logic [2*VW-1:0] chk_prod_a, chk_prod_c;
   logic            chk_live_q;

   assign chk_prod_a = nominal_voltage_value_q * curr_rms[0];
   assign chk_prod_c = volt_rms[2] * curr_rms[2];

   // checks start one edge after reset release; the releasing edge still
   // shows reset values, so comparing there would be a false failure
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         chk_live_q <= 1'b0;
      end else begin
         chk_live_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n || !chk_live_q);

   reserved_bit_zero_a: assert property (
      !cm_q[mcmc_pkg::RSVD_BIT])
      else $error("reserved compute-mode bit became set");

   mode_write_a: assert property (
      wr_en && wr_idx == mcmc_pkg::COMPUTE_MODE_IDX && wr_strb == 4'hF
      |=> cm_q == ($past(wr_data[15:0]) & 16'h7FFF))
      else $error("compute-mode write not stored");

   mode_readback_a: assert property (
      s_axi_arvalid && s_axi_arready && rd_idx == mcmc_pkg::COMPUTE_MODE_IDX
      |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(cm_q)} && !s_axi_rdata[15])
      else $error("compute-mode read returned wrong value");

   angle_off_a: assert property (
      cm_q[10:9] == 2'b11 ##1 cm_q[10:9] == 2'b11
      |-> !angle_volt_curr_q && !angle_volt_volt_q && !angle_curr_curr_q)
      else $error("angles still measured when disabled");

   angle_vv_a: assert property (
      cm_q[10:9] == 2'b01 |=> angle_volt_volt_q && !angle_volt_curr_q)
      else $error("voltage-to-voltage angle not selected");

   nominal_used_a: assert property (
      cm_q[11] |=> apparent_power_q[0] ==
         {1'b0, $past(chk_prod_a[2*VW-1 -: PW-1])})
      else $error("phase A apparent power ignores nominal voltage");

   measured_used_a: assert property (
      !cm_q[13] |=> apparent_power_q[2] ==
         {1'b0, $past(chk_prod_c[2*VW-1 -: PW-1])})
      else $error("phase C apparent power ignores rms voltage");

   out2_mask_a: assert property (
      cm_q[5:3] == 3'h0 |=> pulse_out_sum_q[1] == '0)
      else $error("output 2 sums with no phase enabled");

   out3_active_a: assert property (
      pc_q[8:6] <= 3'h4 ##1 pc_q[8:6] <= 3'h4 |-> pulse_out_active_q[2])
      else $error("output 3 idle on a legal quantity code");

   out1_active_sum_a: assert property (
      pc_q[2:0] == 3'h0 && cm_q[2:0] == 3'h1
      |=> pulse_out_sum_q[0] == (PW+2)'(signed'($past(tot_act_power[0]))))
      else $error("output 1 not phase A active power");

endmodule : mcmc_top
`default_nettype wire

// ### mcmc_top_tb.sv
// self-checking bench for the compute-mode configuration bank
// assumes mcmc_pkg and the design files are compiled ahead of it
`timescale 1ns/1ps
`default_nettype none
module mcmc_top_tb;
   // =========================================================
   // signals; rready stays high, bready comes late to make the slave hold
   logic clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
   logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, rd_v;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] rs;
   logic [2:0][23:0] tot_act_power, tot_react_power, fund_act_power, fund_react_power;
   logic [2:0][23:0] volt_rms, curr_rms;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [2:0][23:0] apparent_power_q;
   wire [2:0][25:0] pulse_out_sum_q;
   wire [2:0] pulse_out_active_q;
   wire angle_volt_curr_q, angle_volt_volt_q, angle_curr_curr_q, line_frequency_select;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   // phase a weight per quantity code; apparent is 2 from the rms inputs below
   localparam logic [25:0] BASE [5] = '{26'h1, 26'h10, 26'h2, 26'h100, 26'h1000};

   mcmc_top uut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tot_act_power,
      .tot_react_power, .fund_act_power, .fund_react_power, .volt_rms, .curr_rms,
      .apparent_power_q, .pulse_out_sum_q, .pulse_out_active_q, .angle_volt_curr_q,
      .angle_volt_volt_q, .angle_curr_curr_q, .line_frequency_select);

   initial forever #10 clk = ~clk;

   // the whole run needs well under 1000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         $display("[FAIL] %0t timeout", $time);
         error_cnt++;
         end_sim();
      end
   end

   task automatic chk(input logic [79:0] g, e, input string m);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, m, g, e);
      end
   endtask : chk

   // =========================================================
   // bus cycles; each channel drops valid at the edge that took it
   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      bit a = 1, w = 1;
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 0;
      while (a | w) begin
         @(posedge clk);
         if (s_axi_awready) a = 0;
         if (s_axi_wready) w = 0;
         s_axi_awvalid <= a;
         s_axi_wvalid <= w;
      end
      // late bready: the response must stand until it is taken
      repeat (2) @(posedge clk);
      s_axi_bready <= 1;
      do @(posedge clk); while (!s_axi_bvalid);
      chk(s_axi_bresp, mcmc_pkg::RESP_OKAY, "bresp");
   endtask : wr

   task automatic rd(input logic [15:0] i, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd

   // =========================================================
   // scenarios
   task automatic t_reset();
      rd(mcmc_pkg::COMPUTE_MODE_IDX, rd_v, rs);
      chk({rs, rd_v}, {2'h0, 32'h01FF}, "mode reset");
      rd(mcmc_pkg::PULSE_CFG_IDX, rd_v, rs);
      chk({rs, rd_v}, {2'h0, 32'h0E88}, "cfg reset");
      chk({angle_volt_curr_q, angle_volt_volt_q, angle_curr_curr_q}, 3'h4, "angle");
      chk(line_frequency_select, 1'h0, "freq reset");
      rd(16'h0000, rd_v, rs);
      chk({rs, rd_v}, {2'h2, 32'h0}, "unmapped");
      $display("test reset done");
   endtask : t_reset

   task automatic t_sum();
      logic [25:0] b;
      wr(mcmc_pkg::COMPUTE_MODE_IDX, 32'hC19D); // masks 101, 011, 110 and bit 15
      rd(mcmc_pkg::COMPUTE_MODE_IDX, rd_v, rs);
      chk(rd_v, 32'h419D, "readback");
      chk(line_frequency_select, 1'h1, "freq");
      for (int c = 0; c < 8; c++) begin
         wr(mcmc_pkg::PULSE_CFG_IDX, 32'(c * 73)); // same code on all three outputs
         repeat (3) @(posedge clk);
         b = c < 5 ? BASE[c] : 26'h0;
         chk(pulse_out_sum_q, {26'(6 * b), 26'(3 * b), 26'(5 * b)}, "sum");
         chk(pulse_out_active_q, {3{c < 5}}, "active");
      end
      $display("test sums done");
   endtask : t_sum

   task automatic t_nom();
      wr(mcmc_pkg::NOM_VOLT_IDX, 32'h400000);
      wr(mcmc_pkg::PULSE_CFG_IDX, 32'h0); // total active power on all outputs
      chk(apparent_power_q, {24'h8, 24'h4, 24'h2}, "measured");
      wr(mcmc_pkg::COMPUTE_MODE_IDX, 32'h29F9); // nominal on a and c, output 1 phase a only
      repeat (3) @(posedge clk);
      chk(apparent_power_q, {24'h4, 24'h4, 24'h1}, "nominal");
      chk(pulse_out_sum_q, {26'h7, 26'h7, 26'h1}, "active sums");
      $display("test nominal done");
   endtask : t_nom

   task automatic t_angle();
      for (int a = 0; a < 4; a++) begin
         wr(mcmc_pkg::COMPUTE_MODE_IDX, 32'(a << 9));
         repeat (2) @(posedge clk);
         chk({angle_volt_curr_q, angle_volt_volt_q, angle_curr_curr_q}, 3'h4 >> a, "angle");
      end
      $display("test angle done");
   endtask : t_angle

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // =========================================================
   // distinct weights per quantity and phase keep every mix apart
   initial begin
      for (int p = 0; p < 3; p++) begin
         tot_act_power[p] = 24'(1 << p);
         tot_react_power[p] = 24'(16 << p);
         fund_act_power[p] = 24'(256 << p);
         fund_react_power[p] = 24'(4096 << p);
         volt_rms[p] = 24'h800000;
         curr_rms[p] = 24'(8 << p);
      end
      repeat (4) @(posedge clk);
      arst_n <= 1;
      @(posedge clk);
      t_reset();
      t_sum();
      t_nom();
      t_angle();
      end_sim();
   end
endmodule : mcmc_top_tb
`default_nettype wire
